/* design/psd_decoder.sv */
// Sequence playback decoder: fetches duty words, chains sequences, drives compares.
// Assumes a single-beat read master with one read outstanding and synchronous inputs.
`timescale 1ns/1ps
`include "psd_regs.svh"
module psd_decoder (
	input  wire logic                   CLK_SYS_I,
	input  wire logic                   RST_N_I,
	input  wire logic [1:0]             PLAYBACK_LAUNCH_TASK_I,
	input  wire logic                   SINGLE_ADVANCE_TASK_I,
	input  wire logic                   STOP_TASK_I,
	input  wire logic [`PSD_ADDR_W-1:0] TABLE_START_POINTER_0_I,
	input  wire logic [`PSD_ADDR_W-1:0] TABLE_START_POINTER_1_I,
	input  wire logic [`PSD_CNT_W-1:0]  TABLE_WORD_COUNT_0_I,
	input  wire logic [`PSD_CNT_W-1:0]  TABLE_WORD_COUNT_1_I,
	input  wire logic [`PSD_DLY_W-1:0]  REFRESH_0_I,
	input  wire logic [`PSD_DLY_W-1:0]  REFRESH_1_I,
	input  wire logic [`PSD_DLY_W-1:0]  TAIL_GAP_PERIODS_0_I,
	input  wire logic [`PSD_DLY_W-1:0]  TAIL_GAP_PERIODS_1_I,
	input  wire logic [`PSD_LOOP_W-1:0] REPEAT_COUNT_I,
	input  wire logic                   MANUAL_ADVANCE_MODE_I,
	input  wire logic [1:0]             LOAD_MODE_I,
	input  wire logic [`PSD_CMP_W-1:0]  PERIOD_LIMIT_I,
	output logic                        DMA_RD_VALID_O,
	input  wire logic                   DMA_RD_READY_I,
	output logic [`PSD_ADDR_W-1:0]      DMA_ADDR_O,
	input  wire logic                   DMA_RDATA_VALID_I,
	output logic                        DMA_RDATA_READY_O,
	input  wire logic [`PSD_WORD_W-1:0] DMA_RDATA_I,
	output logic [`PSD_CMP_W-1:0]       COMPARE_0_O,
	output logic [`PSD_CMP_W-1:0]       COMPARE_1_O,
	output logic [`PSD_CMP_W-1:0]       COMPARE_2_O,
	output logic [`PSD_CMP_W-1:0]       COMPARE_3_O,
	output logic [`PSD_CHANNELS-1:0]    POLARITY_O,
	output logic [`PSD_CMP_W-1:0]       ACTIVE_TOP_O,
	output logic [`PSD_CMP_W-1:0]       PERIOD_COUNT_O,
	output logic                        RUNNING_O,
	output logic                        CYCLE_DONE_EVENT_O,
	output logic [1:0]                  PLAYBACK_BEGAN_EVENT_O,
	output logic [1:0]                  PLAYBACK_FINISHED_EVENT_O,
	output logic                        ALL_REPEATS_DONE_EVENT_O,
	output logic                        STOPPED_EVENT_O
);
	psd_pkg::psd_state_t st_reg, st_next;
	logic                   run_reg;
	logic                   seq_reg;
	logic [`PSD_ADDR_W-1:0] addr_reg;
	logic [`PSD_CNT_W-1:0]  fetch_left_reg;
	logic [`PSD_CNT_W-1:0]  apply_left_reg;
	logic [`PSD_DLY_W-1:0]  rep_reg;
	logic [`PSD_DLY_W-1:0]  gap_cfg_reg;
	logic [`PSD_DLY_W-1:0]  gap_left_reg;
	logic [`PSD_LOOP_W-1:0] loops_reg;
	logic                   first_reg;
	logic                   rd_pend_reg;
	logic [1:0]             start_pend_reg;
	logic                   stop_pend_reg;
	logic                   step_due_reg;
	logic [2:0]             stage_cnt_reg;
	logic                   val_rdy_reg;
	psd_pkg::psd_word_t     stage_reg [`PSD_CHANNELS];
	psd_pkg::psd_word_t     cmp_reg [`PSD_CHANNELS];
	logic [`PSD_CMP_W-1:0]  wave_top_reg;
	logic [1:0]             began_reg;
	logic [1:0]             fin_reg;
	logic                   done_reg;
	logic                   stopped_reg;

	// FIFO and period timer hookup
	wire                    fifo_in_ready;
	wire                    fifo_out_valid;
	psd_pkg::psd_word_t     fifo_out_data;
	wire                    cyc_done;
	logic                   launch;
	logic                   launch_seq;
	logic                   apply;
	logic                   restart;
	logic [`PSD_CMP_W-1:0]  top_src;

	// Words per applied value, by load mode
	wire       wave = (LOAD_MODE_I == `PSD_LOAD_WAVE);
	wire [2:0] wpl  = (LOAD_MODE_I == `PSD_LOAD_COMMON) ? 3'h1 :
	                  (LOAD_MODE_I == `PSD_LOAD_GROUP) ? 3'h2 : 3'h4;
	wire       more = (apply_left_reg >= `PSD_CNT_W'(wpl));
	wire       pop  = fifo_out_valid && !val_rdy_reg && !launch;
	wire       busy = (st_reg == psd_pkg::ST_LOAD) || (st_reg == psd_pkg::ST_PLAY);

	// Read master: one word in flight, only while the FIFO has room
	assign DMA_RD_VALID_O    = busy && fetch_left_reg != '0 && !rd_pend_reg && fifo_in_ready;
	assign DMA_ADDR_O        = addr_reg;
	assign DMA_RDATA_READY_O = fifo_in_ready;

	// Application moments
	wire first_load = (st_reg == psd_pkg::ST_LOAD) && !run_reg && val_rdy_reg;
	wire chain_load = (st_reg == psd_pkg::ST_LOAD) && run_reg && cyc_done && val_rdy_reg;
	wire play_adv   = (st_reg == psd_pkg::ST_PLAY) && cyc_done &&
	                  (MANUAL_ADVANCE_MODE_I ? step_due_reg : (rep_reg == '0));
	wire seq_over   = play_adv && !more;
	wire [`PSD_DLY_W-1:0] gap_eff = MANUAL_ADVANCE_MODE_I ? '0 : gap_cfg_reg;
	wire gap_end    = (seq_over && REPEAT_COUNT_I != '0 && gap_eff == '0) ||
	                  (st_reg == psd_pkg::ST_GAP && cyc_done && gap_left_reg <= `PSD_DLY_W'(1));
	wire last_loop  = (loops_reg + 1'b1 >= REPEAT_COUNT_I);
	wire stop_take  = stop_pend_reg && (cyc_done || !run_reg);
	wire start_take = (start_pend_reg != 2'h0) && !rd_pend_reg && !stop_take;

	// Previous value repeats when the next is not fetched yet
	assign apply   = first_load || chain_load || (play_adv && more && val_rdy_reg);
	assign restart = first_load;

	// Start task, or the chained sequence at a gap end
	always_comb begin
		launch     = 1'b0;
		launch_seq = 1'b0;
		if (start_take) begin
			launch     = 1'b1;
			launch_seq = start_pend_reg[1] && !start_pend_reg[0];
		end else if (gap_end && !stop_take) begin
			launch     = !(seq_reg && last_loop);
			launch_seq = !seq_reg;
		end
	end

	// Top source: RAM word in wave mode, else the limit input at wrap
	assign top_src = wave ? (apply ? stage_reg[3][`PSD_CMP_W-1:0] : wave_top_reg)
	                      : PERIOD_LIMIT_I;

	always_comb begin
		st_next = st_reg;
		if (stop_take) begin
			st_next = psd_pkg::ST_IDLE;
		end else if (launch) begin
			st_next = psd_pkg::ST_LOAD;
		end else if (gap_end) begin
			st_next = psd_pkg::ST_HOLD;
		end else if (apply) begin
			st_next = psd_pkg::ST_PLAY;
		end else if (seq_over) begin
			st_next = (REPEAT_COUNT_I == '0) ? psd_pkg::ST_HOLD : psd_pkg::ST_GAP;
		end else begin
			case (st_reg)
				psd_pkg::ST_IDLE,
				psd_pkg::ST_LOAD,
				psd_pkg::ST_PLAY,
				psd_pkg::ST_GAP,
				psd_pkg::ST_HOLD: st_next = st_reg;
				default:          st_next = psd_pkg::ST_IDLE;
			endcase
		end
	end

	psd_fifo #(
		.W(`PSD_WORD_W),
		.D(`PSD_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_SYS_I),
		.rst_n_i     (RST_N_I),
		.flush_i     (launch),
		.in_valid_i  (DMA_RDATA_VALID_I),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (DMA_RDATA_I),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_out_data)
	);

	psd_period u_period (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.run_i     (run_reg),
		.restart_i (restart),
		.top_i     (top_src),
		.end_o     (cyc_done),
		.count_o   (PERIOD_COUNT_O),
		.top_o     (ACTIVE_TOP_O)
	);

	// Task capture and control state
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_reg         <= psd_pkg::ST_IDLE;
			run_reg        <= 1'b0;
			start_pend_reg <= 2'h0;
			stop_pend_reg  <= 1'b0;
			step_due_reg   <= 1'b0;
			loops_reg      <= '0;
		end else begin
			st_reg <= st_next;
			if (restart) begin
				run_reg <= 1'b1;
			end else if (stop_take) begin
				run_reg <= 1'b0;
			end
			start_pend_reg <= start_take ? PLAYBACK_LAUNCH_TASK_I
			                             : (start_pend_reg | PLAYBACK_LAUNCH_TASK_I);
			stop_pend_reg  <= STOP_TASK_I || (stop_pend_reg && !stop_take);
			if (SINGLE_ADVANCE_TASK_I && st_reg == psd_pkg::ST_PLAY) begin
				step_due_reg <= 1'b1;
			end else if (play_adv || launch) begin
				step_due_reg <= 1'b0;
			end
			if (start_take) begin
				loops_reg <= '0;
			end else if (gap_end && seq_reg) begin
				loops_reg <= loops_reg + 1'b1;
			end
		end
	end

	// Sequence capture, fetch and cadence counters
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seq_reg        <= 1'b0;
			addr_reg       <= '0;
			fetch_left_reg <= '0;
			apply_left_reg <= '0;
			rep_reg        <= '0;
			gap_cfg_reg    <= '0;
			gap_left_reg   <= '0;
			first_reg      <= 1'b0;
			rd_pend_reg    <= 1'b0;
		end else begin
			if (launch) begin
				seq_reg        <= launch_seq;
				addr_reg       <= launch_seq ? TABLE_START_POINTER_1_I
				                             : TABLE_START_POINTER_0_I;
				fetch_left_reg <= launch_seq ? TABLE_WORD_COUNT_1_I : TABLE_WORD_COUNT_0_I;
				apply_left_reg <= launch_seq ? TABLE_WORD_COUNT_1_I : TABLE_WORD_COUNT_0_I;
				rep_reg        <= launch_seq ? REFRESH_1_I : REFRESH_0_I;
				gap_cfg_reg    <= launch_seq ? TAIL_GAP_PERIODS_1_I : TAIL_GAP_PERIODS_0_I;
				first_reg      <= 1'b1;
			end else begin
				if (DMA_RD_VALID_O && DMA_RD_READY_I) begin
					addr_reg       <= addr_reg + `PSD_ADDR_STEP;
					fetch_left_reg <= fetch_left_reg - 1'b1;
				end
				if (apply) begin
					apply_left_reg <= apply_left_reg - `PSD_CNT_W'(wpl);
					rep_reg        <= seq_reg ? REFRESH_1_I : REFRESH_0_I;
					gap_cfg_reg    <= seq_reg ? TAIL_GAP_PERIODS_1_I : TAIL_GAP_PERIODS_0_I;
					first_reg      <= 1'b0;
				end else if (st_reg == psd_pkg::ST_PLAY && cyc_done && rep_reg != '0) begin
					rep_reg <= rep_reg - 1'b1;
				end
				if (seq_over) begin
					gap_left_reg <= gap_eff;
				end else if (st_reg == psd_pkg::ST_GAP && cyc_done) begin
					gap_left_reg <= gap_left_reg - 1'b1;
				end
			end
			if (DMA_RD_VALID_O && DMA_RD_READY_I) begin
				rd_pend_reg <= 1'b1;
			end else if (DMA_RDATA_VALID_I && fifo_in_ready) begin
				rd_pend_reg <= 1'b0;
			end
		end
	end

	// Staging of one value's words
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			stage_cnt_reg <= '0;
			val_rdy_reg   <= 1'b0;
		end else if (launch || apply) begin
			stage_cnt_reg <= '0;
			val_rdy_reg   <= 1'b0;
		end else if (pop) begin
			stage_cnt_reg <= stage_cnt_reg + 1'b1;
			val_rdy_reg   <= (stage_cnt_reg + 1'b1 == wpl);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (pop) begin
			stage_reg[stage_cnt_reg[1:0]] <= fifo_out_data;
		end
	end

	// Per-channel compare registers, routed by load mode
	genvar ch;
	generate
		for (ch = 0; ch < `PSD_CHANNELS; ch++) begin : g_ch
			wire [1:0] src = (LOAD_MODE_I == `PSD_LOAD_COMMON) ? 2'h0 :
			                 (LOAD_MODE_I == `PSD_LOAD_GROUP) ? 2'(ch / 2) : 2'(ch);
			wire       off = wave && (ch == `PSD_CHANNELS - 1);
			always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					cmp_reg[ch] <= '0;
				end else if (apply) begin
					cmp_reg[ch] <= off ? '0 : stage_reg[src];
				end
			end
			assign POLARITY_O[ch] = cmp_reg[ch][`PSD_POL_BIT];
		end
	endgenerate

	assign COMPARE_0_O = cmp_reg[0][`PSD_CMP_W-1:0];
	assign COMPARE_1_O = cmp_reg[1][`PSD_CMP_W-1:0];
	assign COMPARE_2_O = cmp_reg[2][`PSD_CMP_W-1:0];
	assign COMPARE_3_O = cmp_reg[3][`PSD_CMP_W-1:0];

	// Wave top and events
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wave_top_reg <= `PSD_TOP_RESET;
			began_reg    <= 2'h0;
			fin_reg      <= 2'h0;
			done_reg     <= 1'b0;
			stopped_reg  <= 1'b0;
		end else begin
			if (apply && wave) begin
				wave_top_reg <= stage_reg[3][`PSD_CMP_W-1:0];
			end
			began_reg   <= (apply && first_reg) ? (seq_reg ? 2'h2 : 2'h1) : 2'h0;
			fin_reg     <= (apply && apply_left_reg < `PSD_CNT_W'(wpl) + `PSD_CNT_W'(wpl))
			               ? (seq_reg ? 2'h2 : 2'h1) : 2'h0;
			done_reg    <= gap_end && seq_reg && last_loop && !stop_take;
			stopped_reg <= stop_take;
		end
	end

	assign PLAYBACK_BEGAN_EVENT_O    = began_reg;
	assign PLAYBACK_FINISHED_EVENT_O = fin_reg;
	assign ALL_REPEATS_DONE_EVENT_O  = done_reg;
	assign STOPPED_EVENT_O           = stopped_reg;
	assign CYCLE_DONE_EVENT_O        = cyc_done;
	assign RUNNING_O                 = run_reg;
endmodule : psd_decoder

/* design/psd_fifo.sv */
// Small FIFO between the read master and the decoder.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module psd_fifo #(
	parameter int W = 16,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   cnt_reg;
	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;
	assign in_ready_o  = (cnt_reg != (AW+1)'(D));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem[rd_reg];
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_reg] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (flush_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : psd_fifo

/* design/psd_period.sv */
// Period timer: counts one PWM period and marks its last cycle.
// Assumes top is sampled only at restart and at each period wrap.
`timescale 1ns/1ps
`include "psd_regs.svh"
module psd_period (
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 run_i,
	input  wire logic                 restart_i,
	input  wire logic [`PSD_CMP_W-1:0] top_i,
	output logic                      end_o,
	output logic [`PSD_CMP_W-1:0]     count_o,
	output logic [`PSD_CMP_W-1:0]     top_o
);
	logic [`PSD_CMP_W-1:0] cnt_reg;
	logic [`PSD_CMP_W-1:0] top_reg;
	assign end_o   = run_i && !restart_i && (top_reg == '0 || cnt_reg >= top_reg - 1'b1);
	assign count_o = cnt_reg;
	assign top_o   = top_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			top_reg <= `PSD_TOP_RESET;
		end else if (restart_i || end_o) begin
			cnt_reg <= '0;
			top_reg <= top_i;
		end else if (run_i) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : psd_period

/* inc/psd_pkg.sv */
// Types shared by the sequence playback decoder files.
// Assumes psd_regs.svh is on the include path.
`include "psd_regs.svh"
package psd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_LOAD = 3'h1,
		ST_PLAY = 3'h3,
		ST_GAP  = 3'h2,
		ST_HOLD = 3'h6
	} psd_state_t;
	typedef logic [`PSD_WORD_W-1:0] psd_word_t;
endpackage : psd_pkg

/* inc/psd_regs.svh */
// Constants of the sequence playback decoder: widths, encodings, depths.
// Assumes it is included by bare name into the package and design files.
`ifndef PSD_REGS_SVH
`define PSD_REGS_SVH
`define PSD_WORD_W      16
`define PSD_CMP_W       15
`define PSD_POL_BIT     15
`define PSD_CNT_W       15
`define PSD_DLY_W       24
`define PSD_LOOP_W      16
`define PSD_ADDR_W      32
`define PSD_ADDR_STEP   32'h0000_0002
`define PSD_CHANNELS    4
`define PSD_FIFO_DEPTH  4
`define PSD_LOAD_COMMON 2'h0
`define PSD_LOAD_GROUP  2'h1
`define PSD_LOAD_INDIV  2'h2
`define PSD_LOAD_WAVE   2'h3
`define PSD_TOP_RESET   15'h03e8
`endif

/* verification/psd_assertions.sv */
// Concurrent checks on the ports of the sequence playback decoder.
// Assumes it is bound into psd_decoder; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`include "psd_regs.svh"
module psd_chk (
	input wire logic			CLK_SYS_I,
	input wire logic			RST_N_I,
	input wire logic [1:0]			LOAD_MODE_I,
	input wire logic			DMA_RD_VALID_O,
	input wire logic			DMA_RD_READY_I,
	input wire logic [`PSD_ADDR_W-1:0]	DMA_ADDR_O,
	input wire logic [`PSD_CMP_W-1:0]	COMPARE_0_O,
	input wire logic [`PSD_CMP_W-1:0]	COMPARE_3_O,
	input wire logic [`PSD_CMP_W-1:0]	ACTIVE_TOP_O,
	input wire logic			RUNNING_O,
	input wire logic			CYCLE_DONE_EVENT_O,
	input wire logic [1:0]			PLAYBACK_BEGAN_EVENT_O,
	input wire logic [1:0]			PLAYBACK_FINISHED_EVENT_O,
	input wire logic			ALL_REPEATS_DONE_EVENT_O,
	input wire logic			STOPPED_EVENT_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	a_cmp_at_end:
		assert property (RUNNING_O && $past(RUNNING_O) && $changed(COMPARE_0_O)
			|-> $past(CYCLE_DONE_EVENT_O)) else $error("compare changed off period end");
	a_top_at_end:
		assert property (LOAD_MODE_I != `PSD_LOAD_WAVE && RUNNING_O && $past(RUNNING_O)
			&& $changed(ACTIVE_TOP_O) |-> $past(CYCLE_DONE_EVENT_O))
		else $error("period limit taken mid-period");
	a_wave_ch3_zero:
		assert property (LOAD_MODE_I == `PSD_LOAD_WAVE && RUNNING_O && $past(RUNNING_O)
			|-> COMPARE_3_O == 15'h0) else $error("channel 3 driven in wave mode");
	a_began_pulse:
		assert property (|PLAYBACK_BEGAN_EVENT_O |-> RUNNING_O ##1 PLAYBACK_BEGAN_EVENT_O == 2'h0)
		else $error("began event wrong");
	a_finish_pulse:
		assert property (|PLAYBACK_FINISHED_EVENT_O |-> RUNNING_O ##1
			PLAYBACK_FINISHED_EVENT_O == 2'h0) else $error("finished event wrong");
	a_hold_after_done:
		assert property (ALL_REPEATS_DONE_EVENT_O |=> !ALL_REPEATS_DONE_EVENT_O
			&& $stable(COMPARE_0_O) [*8]) else $error("value not held after done");
	a_req_holds:
		assert property (DMA_RD_VALID_O && !DMA_RD_READY_I |=> DMA_RD_VALID_O
			&& $stable(DMA_ADDR_O)) else $error("read request dropped or moved");
	a_stop_quiet:
		assert property (STOPPED_EVENT_O |-> !RUNNING_O) else $error("running after stop");
	c_began: cover property (|PLAYBACK_BEGAN_EVENT_O);
	c_done: cover property (ALL_REPEATS_DONE_EVENT_O);
	c_stop: cover property (STOPPED_EVENT_O);
endmodule : psd_chk
bind psd_decoder psd_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
	.LOAD_MODE_I(LOAD_MODE_I), .DMA_RD_VALID_O(DMA_RD_VALID_O),
	.DMA_RD_READY_I(DMA_RD_READY_I), .DMA_ADDR_O(DMA_ADDR_O), .COMPARE_0_O(COMPARE_0_O),
	.COMPARE_3_O(COMPARE_3_O), .ACTIVE_TOP_O(ACTIVE_TOP_O), .RUNNING_O(RUNNING_O),
	.CYCLE_DONE_EVENT_O(CYCLE_DONE_EVENT_O), .PLAYBACK_BEGAN_EVENT_O(PLAYBACK_BEGAN_EVENT_O),
	.PLAYBACK_FINISHED_EVENT_O(PLAYBACK_FINISHED_EVENT_O),
	.ALL_REPEATS_DONE_EVENT_O(ALL_REPEATS_DONE_EVENT_O), .STOPPED_EVENT_O(STOPPED_EVENT_O));

/* verification/psd_ram_model.sv */
// Behavioural read memory on the far side of the decoder's read master.
// Assumes one read outstanding; each word is built from its own byte address.
`timescale 1ns/1ps
module psd_ram_model (
	input wire logic	clk_i,
	input wire logic	rst_n_i,
	input wire logic	slow_i,
	input wire logic	rd_valid_i,
	output logic		rd_ready_o,
	input wire logic [31:0]	addr_i,
	output logic		rdata_valid_o,
	input wire logic	rdata_ready_i,
	output logic [15:0]	rdata_o
);
	logic		busy_reg;
	logic [1:0]	tick_reg;
	logic [31:0]	addr_reg;
	// Slow mode answers one cycle in four, so a short period outruns the fetch
	wire		gate = !slow_i || tick_reg == 2'h3;
	wire [15:0]	word = {addr_reg[2], addr_reg[15:1]};
	assign rd_ready_o = !busy_reg && gate;
	assign rdata_valid_o = busy_reg && gate;
	// Outside a valid beat the lines show the inverse, never the word itself
	assign rdata_o = rdata_valid_o ? word : ~word;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
			tick_reg <= 2'h0;
			addr_reg <= 32'h0;
		end else begin
			tick_reg <= tick_reg + 2'h1;
			if (rd_valid_i && rd_ready_o) begin
				busy_reg <= 1'b1;
				addr_reg <= addr_i;
			end else if (rdata_valid_o && rdata_ready_i) begin
				busy_reg <= 1'b0;
			end
		end
	end
endmodule : psd_ram_model

/* verification/tb.sv */
// Self-checking bench for the sequence playback decoder.
// Assumes psd_ram_model answers reads with a word derived from the address.
`timescale 1ns/1ps
`include "psd_regs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
	logic		clk, rst_n, st, sp, mm, slow;
	logic [1:0]	lt, lm, bg, fn;
	logic [31:0]	p0, p1, ad;
	logic [14:0]	n0, n1, tp, at, pc;
	logic [14:0]	c [4];
	logic [23:0]	r0, r1, g0, g1;
	logic [15:0]	rc, rd, last;
	logic [3:0]	pol;
	logic		rv, rr, dv, dr, run, cd, dn, so;
	int		miscompares, checks_done, tick, gcnt, ga, gb;
	int		evq [$];
	int		gq [$];
	logic [15:0]	vq [$];
	psd_decoder u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PLAYBACK_LAUNCH_TASK_I(lt),
		.SINGLE_ADVANCE_TASK_I(st), .STOP_TASK_I(sp), .TABLE_START_POINTER_0_I(p0),
		.TABLE_START_POINTER_1_I(p1), .TABLE_WORD_COUNT_0_I(n0), .TABLE_WORD_COUNT_1_I(n1),
		.REFRESH_0_I(r0), .REFRESH_1_I(r1), .TAIL_GAP_PERIODS_0_I(g0),
		.TAIL_GAP_PERIODS_1_I(g1), .REPEAT_COUNT_I(rc), .MANUAL_ADVANCE_MODE_I(mm),
		.LOAD_MODE_I(lm), .PERIOD_LIMIT_I(tp), .DMA_RD_VALID_O(rv), .DMA_RD_READY_I(rr),
		.DMA_ADDR_O(ad), .DMA_RDATA_VALID_I(dv), .DMA_RDATA_READY_O(dr), .DMA_RDATA_I(rd),
		.COMPARE_0_O(c[0]), .COMPARE_1_O(c[1]), .COMPARE_2_O(c[2]), .COMPARE_3_O(c[3]),
		.POLARITY_O(pol), .ACTIVE_TOP_O(at), .PERIOD_COUNT_O(pc), .RUNNING_O(run),
		.CYCLE_DONE_EVENT_O(cd), .PLAYBACK_BEGAN_EVENT_O(bg), .PLAYBACK_FINISHED_EVENT_O(fn),
		.ALL_REPEATS_DONE_EVENT_O(dn), .STOPPED_EVENT_O(so));
	psd_ram_model u_ram (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .rd_valid_i(rv),
		.rd_ready_o(rr), .addr_i(ad), .rdata_valid_o(dv), .rdata_ready_i(dr), .rdata_o(rd));
	function automatic logic [15:0] w(input logic [31:0] a);
		return {a[2], a[15:1]};
	endfunction : w
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		tick++;
		if (tick == 30000) begin
			miscompares++;
			print_verdict;
		end
	end
	// Logs applied channel 0 values, periods between them, and events
	always @(negedge clk) begin
		if ({pol[0], c[0]} !== last) begin
			vq.push_back({pol[0], c[0]});
			gq.push_back(gcnt);
			gcnt = 0;
			last = {pol[0], c[0]};
		end
		if (cd === 1'b1) gcnt++;
		for (int i = 0; i < 2; i++) begin
			if (bg[i]) evq.push_back(1 + i);
			if (fn[i]) evq.push_back(3 + i);
		end
		if (dn) evq.push_back(5);
		if (so) evq.push_back(6);
	end
	task automatic print_verdict;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	task automatic pulse(input logic [3:0] p);
		@(negedge clk);
		{sp, st, lt} = p;
		@(negedge clk);
		{sp, st, lt} = 4'h0;
	endtask : pulse
	task automatic cfg(input logic [31:0] p, input logic [14:0] n, input logic [23:0] r,
		input logic [15:0] k);
		p0 = p;
		n0 = n;
		r0 = r;
		rc = k;
		evq.delete();
		vq.delete();
		gq.delete();
	endtask : cfg
	task automatic wait_q(input int n);
		int k;
		k = 0;
		while (evq.size() < n && k < 5000) begin
			@(negedge clk);
			k++;
		end
		`CHK(evq.size() >= n, 1'b1)
	endtask : wait_q
	task automatic wait_cd;
		int k;
		k = 0;
		while (cd !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_cd
	task automatic chk_ev(input int n, input logic [31:0] code);
		`CHK(evq.size(), n)
		for (int k = 0; k < n; k++)
			`CHK(evq[k], int'(code[4 * (n - 1 - k) +: 4]))
	endtask : chk_ev
	task automatic chk_vals(input int i0, input logic [31:0] base, input int n);
		for (int k = 0; k < n; k++)
			`CHK(vq[i0 + k], w(base + 2 * k))
	endtask : chk_vals
	task automatic stop_run;
		cfg(p0, n0, r0, rc);
		pulse(4'h8);
		wait_q(1);
		chk_ev(1, 32'h6);
		`CHK(run, 1'b0)
	endtask : stop_run
	task automatic t_single(input logic s, input logic [23:0] r, input logic [14:0] t,
		input logic [31:0] b);
		slow = s;
		tp = t;
		cfg(b, 15'h4, r, 16'h0);
		pulse(4'h1);
		wait_q(1);
		p0 = 32'h900;
		wait_q(2);
		repeat (40) @(negedge clk);
		chk_ev(2, 32'h13);
		`CHK(vq.size(), 4)
		chk_vals(0, b, 4);
		for (int k = 1; k < 4 && !s; k++)
			`CHK(gq[k], r + 1)
		stop_run;
		slow = 1'b0;
		$display("test single done");
	endtask : t_single
	task automatic t_chain(input logic f, input logic [23:0] g, input logic [15:0] k,
		output int gx);
		p1 = 32'h300;
		n1 = 15'h2;
		r1 = 24'h0;
		g0 = g;
		g1 = 24'h0;
		cfg(32'h200, 15'h2, 24'h1, k);
		pulse(f ? 4'h2 : 4'h1);
		wait_q(f ? 7 : 5);
		repeat (40) @(negedge clk);
		`CHK(vq.size(), f ? 6 : 4)
		chk_ev(f ? 7 : 5, f ? 32'h2413245 : 32'h13245);
		chk_vals(0, f ? 32'h300 : 32'h200, 2);
		chk_vals(2, f ? 32'h200 : 32'h300, 2);
		if (f)
			chk_vals(4, 32'h300, 2);
		gx = gq[2];
		stop_run;
		$display("test chain done");
	endtask : t_chain
	task automatic t_manual;
		mm = 1'b1;
		cfg(32'h400, 15'h3, 24'h3, 16'h0);
		pulse(4'h1);
		wait_q(1);
		repeat (48) @(negedge clk);
		`CHK(vq.size(), 1)
		pulse(4'h4);
		repeat (20) @(negedge clk);
		`CHK(vq.size(), 2)
		pulse(4'h4);
		wait_q(2);
		chk_ev(2, 32'h13);
		chk_vals(0, 32'h400, 3);
		stop_run;
		mm = 1'b0;
		$display("test manual done");
	endtask : t_manual
	task automatic t_modes;
		logic [15:0] ch [4];
		logic [7:0] sel;
		for (int m = 1; m < 4; m++) begin
			lm = m[1:0];
			tp = 15'h9;
			cfg(32'h500, 15'h4, 24'h0, 16'h0);
			pulse(4'h1);
			wait_q(2);
			repeat (4) @(negedge clk);
			ch = '{{pol[0], c[0]}, {pol[1], c[1]}, {pol[2], c[2]}, {pol[3], c[3]}};
			sel = (m == 1) ? 8'hfa : 8'he4;
			for (int i = 0; i < 4 - (m / 3); i++)
				`CHK(ch[i], w(32'h500 + 2 * sel[2 * i +: 2]))
			if (m == 3) begin
				`CHK(c[3], 15'h0)
				`CHK({1'b0, at}, w(32'h506) & 16'h7fff)
			end
			stop_run;
		end
		lm = 2'h0;
		$display("test modes done");
	endtask : t_modes
	task automatic t_top;
		tp = 15'h8;
		cfg(32'h600, 15'h1, 24'h0, 16'h0);
		pulse(4'h1);
		wait_q(2);
		wait_cd;
		repeat (3) @(negedge clk);
		tp = 15'hc;
		@(negedge clk);
		`CHK(at, 15'h8)
		`CHK(pc, 15'h3)
		wait_cd;
		@(negedge clk);
		`CHK(at, 15'hc)
		`CHK(pc, 15'h0)
		stop_run;
		$display("test top done");
	endtask : t_top
	initial begin
		{rst_n, st, sp, mm, slow, lt, lm} = '0;
		{p0, p1, n0, n1, r0, r1, g0, g1, rc} = '0;
		tp = 15'h8;
		last = 16'h0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK(at, `PSD_TOP_RESET)
		`CHK({run, dr, rv}, 3'b010)
		t_single(1'b0, 24'h1, 15'h8, 32'h100);
		t_single(1'b1, 24'h0, 15'h4, 32'h140);
		t_chain(1'b0, 24'h1, 16'h1, ga);
		t_chain(1'b0, 24'h3, 16'h1, gb);
		`CHK(gb - ga, 2)
		t_chain(1'b1, 24'h1, 16'h2, ga);
		t_manual;
		t_modes;
		t_top;
		print_verdict;
	end
endmodule : tb
